// *** tb/core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Core side: returns from the latest taken event after a short, stallable delay; a new take restarts the count
module core_model (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic svc_take,
    input  wire logic stall,
    output logic      ret_strobe
);
    logic [1:0] cnt; // Cycles left until the return
    // Stall freezes the count at one, so events can be nested on purpose
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt        <= 2'h0;
            ret_strobe <= 1'b0;
        end else begin
            ret_strobe <= (cnt == 2'h1) && !stall;
            if (svc_take) begin
                cnt <= 2'h2;
            end else if (cnt != 2'h0 && !(cnt == 2'h1 && stall)) begin
                cnt <= cnt - 2'h1;
            end
        end
    end
endmodule : core_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [55:0] periph_req = '0;                // Peripheral request levels
    logic [55:0] sys_mask = '1;                  // All sources forwarded
    logic [55:0] wake_en = '1;                   // All sources may wake
    logic [6:0]  ded_req = '0;                   // Dedicated events
    logic [1:0]  sw_req = '0;                    // Software raises
    logic [15:0] ev_mask = 16'hFFFF;             // Core mask, all open
    logic        assign_wr = 1'b0;
    logic [2:0]  assign_idx = 3'h0;
    logic [31:0] assign_data = 32'h0000_0000;
    logic        stall = 1'b0;                   // Holds the core's return
    wire logic   ret_strobe, svc_take, wake_req;
    wire logic [3:0]  svc_idx;
    wire logic [15:0] lat, pend;
    wire logic [55:0] status;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    int dsrc[12] = '{0, 10, 12, 13, 14, 19, 20, 25, 30, 32, 42, 48};
    int dlvl[12] = '{7, 7, 8, 8, 9, 9, 10, 10, 11, 12, 13, 10};
    int dpos[6] = '{0, 1, 2, 3, 5, 6};
    always #20 clk_sys = ~clk_sys;
    two_stage_event_prioritizer #(.N_SRC(56)) u_two_stage_event_prioritizer (
        .clk_sys(clk_sys), .nrst(nrst), .periph_req(periph_req), .sys_mask(sys_mask),
        .source_wake_enable_bits(wake_en), .ded_req(ded_req), .sw_req(sw_req),
        .event_mask_bits(ev_mask), .assign_wr(assign_wr), .assign_idx(assign_idx),
        .assign_data(assign_data), .ret_strobe(ret_strobe), .event_latch_bits(lat),
        .event_pending_bits(pend), .svc_take(svc_take), .svc_idx(svc_idx),
        .source_status_bits(status), .wake_req(wake_req));
    core_model u_core_model (.clk_sys(clk_sys), .nrst(nrst), .svc_take(svc_take),
        .stall(stall), .ret_strobe(ret_strobe));
    // Prints the verdict and ends the run
    task close_out;
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    // A hang is cut short well above the expected length of the run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            close_out();
        end
    end
    task chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    // Inputs and checks both land 5 ns after the edge, when all is settled
    task step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : step
    task set_in(input int kind, input int b, input logic v);
        case (kind)
            0: periph_req[b] = v;
            1: ded_req[b] = v;
            default: sw_req[b] = v;
        endcase
    endtask : set_in
    // One event from rise to return; the core model answers unaided
    task fire(input int kind, input int b, input int lvl);
        step(1);
        set_in(kind, b, 1'b1);
        step(2);
        chk(lat[lvl] === 1'b1, "latch not set two cycles after the rise");
        step(1);
        chk(svc_take === 1'b1 && svc_idx === lvl[3:0] && pend[lvl] === 1'b1, "not taken");
        chk(lat[lvl] === 1'b0, "latch kept after take");
        set_in(kind, b, 1'b0);
        step(5);
        chk(pend === 16'h0000, "pending not returned");
    endtask : fire
    task wr_word(input logic [2:0] k, input logic [31:0] d);
        step(1);
        assign_wr = 1'b1;
        assign_idx = k;
        assign_data = d;
        step(1);
        assign_wr = 1'b0;
    endtask : wr_word
    initial begin
        repeat (4) @(posedge clk_sys);
        #5;
        chk({lat, pend, svc_take, svc_idx, wake_req, status} === 94'h0, "outputs not cleared");
        nrst = 1'b1;
        // Default routing of at least one source in every level group, 7 to 13
        foreach (dsrc[i]) fire(0, dsrc[i], dlvl[i]);
        foreach (dpos[i]) fire(1, dpos[i], dpos[i]);
        // The non-maskable event is served with every core mask bit clear
        ev_mask = 16'h0000;
        fire(1, 2, 2);
        ev_mask = 16'hFFFF;
        fire(2, 0, 14);
        fire(2, 1, 15);
        step(1);
        ded_req[4] = 1'b1;
        step(4);
        chk(lat[4] === 1'b0 && pend === 16'h0000, "reserved position latched");
        ded_req[4] = 1'b0;
        // Rewritten fields, codes 0, 2, 6 and 8, in three different words
        wr_word(3'h1, 32'h0006_0000);
        fire(0, 12, 13);
        fire(0, 8, 7);
        wr_word(3'h0, 32'h0000_2000);
        fire(0, 3, 9);
        wr_word(3'h6, 32'h8000_0000);
        fire(0, 55, 15);
        // A code past the last level routes nowhere
        wr_word(3'h6, 32'h9000_0000);
        periph_req[55] = 1'b1;
        step(4);
        chk(lat === 16'h0000 && pend === 16'h0000, "code beyond level 15 routed");
        periph_req[55] = 1'b0;
        // Reset in mid-run clears outputs and restores default fields
        nrst = 1'b0;
        step(2);
        chk({lat, pend, svc_take, svc_idx, wake_req, status} === 94'h0, "reset not clean");
        nrst = 1'b1;
        fire(0, 55, 10);
        wr_word(3'h0, 32'h0000_0000);
        wr_word(3'h1, 32'h2211_0000);
        // System mask blocks forwarding but not status or wake
        sys_mask[0] = 1'b0;
        periph_req[0] = 1'b1;
        step(4);
        chk(lat[7] === 1'b0 && pend === 16'h0000, "masked source forwarded");
        chk(status[0] === 1'b1 && wake_req === 1'b1, "status or wake missing");
        wake_en[0] = 1'b0;
        step(2);
        chk(status[0] === 1'b1 && wake_req === 1'b0, "wake raised by a disabled source");
        wake_en[0] = 1'b1;
        periph_req[0] = 1'b0;
        step(1);
        sys_mask[0] = 1'b1;
        // Core mask holds service while the latch stays set
        ev_mask[7] = 1'b0;
        periph_req[0] = 1'b1;
        step(4);
        chk(lat[7] === 1'b1 && pend[7] === 1'b0, "masked event serviced");
        ev_mask[7] = 1'b1;
        step(2);
        chk(svc_idx === 4'h7 && pend[7] === 1'b1, "unmasked event not taken");
        periph_req[1] = 1'b1;
        step(6);
        chk(lat[7] === 1'b0 && pend === 16'h0000, "second source gave new edge");
        periph_req[1:0] = 2'h0;
        // Timer and level 7 together with the core stalled
        stall = 1'b1;
        step(2);
        ded_req[6] = 1'b1;
        periph_req[0] = 1'b1;
        step(3);
        chk(svc_idx === 4'h6 && lat[7] === 1'b1, "wrong event first");
        step(3);
        chk(pend === 16'h0040 && lat[7] === 1'b1, "lower event preempted");
        stall = 1'b0;
        step(6);
        chk(svc_idx === 4'h7, "waiting event not taken after return");
        ded_req[6] = 1'b0;
        periph_req[0] = 1'b0;
        step(6);
        chk(pend === 16'h0000, "pending not returned");
        close_out();
    end
endmodule : tb_top
`default_nettype wire

// *** verilog/event_prio_params.svh ***
// Overview of operation
// - Core stage takes general levels 7 to 15
// - Rank events, zero highest, level 4 reserved
// - Each peripheral source routes to one level; codes above 8 route nowhere
// - Software rewrites each source's level field
// - Field value n selects level n plus 7
// - Sources 0-10 default level 7, 11 reserved
// - Sources 12-13 level 8, 14-19 level 9
// - Sources 20-25 level 10, 26-30 level 11
// - Each assignment word holds eight source fields
// - Edge sets latch in two cycles, pending clears it
// - Edge to pending takes at least three cycles
// - System mask bit gates peripheral event forwarding
// - Core mask bit gates servicing of events 4-15, latch stays
`ifndef EVENT_PRIO_PARAMS_SVH
`define EVENT_PRIO_PARAMS_SVH

// Source counts and assignment layout
`define EVP_NUM_SOURCES  56
`define EVP_FIELDS_WORD  8
`define EVP_FIELD_BITS   4
`define EVP_NUM_EVENTS   16
`define EVP_NUM_GP       9

// Event positions in the core stage
`define EVP_POS_EMU      0
`define EVP_POS_RESET    1
`define EVP_POS_NMI      2
`define EVP_POS_EXC      3
`define EVP_POS_RSVD     4
`define EVP_POS_HWERR    5
`define EVP_POS_TIMER    6
`define EVP_POS_GP_BASE  7
`define EVP_POS_SW_LO    14

// Assignment field codes at reset (level minus seven)
`define EVP_CODE_LVL7    4'h0
`define EVP_CODE_LVL8    4'h1
`define EVP_CODE_LVL9    4'h2
`define EVP_CODE_LVL10   4'h3
`define EVP_CODE_LVL11   4'h4
`define EVP_CODE_LVL12   4'h5
`define EVP_CODE_LVL13   4'h6

// Events that no mask can hold off
`define EVP_UNMASKABLE   16'h000F

`endif

// *** verilog/event_prio_pkg.sv ***
package event_prio_pkg;
    // Index of one core-stage event
    typedef logic [3:0] event_idx_t;
    // One assignment field
    typedef logic [3:0] level_code_t;
    // One bit per core-stage event
    typedef logic [15:0] event_vec_t;
endpackage : event_prio_pkg

// *** verilog/source_router.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "event_prio_params.svh"

module source_router #(
    parameter int N_SRC = `EVP_NUM_SOURCES
) (
    input  wire logic [N_SRC-1:0]                     req,
    input  wire logic [N_SRC-1:0]                     mask,
    input  wire logic [N_SRC-1:0][`EVP_FIELD_BITS-1:0] field,
    output logic      [`EVP_NUM_GP-1:0]               gp_req
);
    // Pure combining logic; the core stage registers the result
    always_comb begin
        gp_req = '0;
        for (int s = 0; s < N_SRC; s++) begin
            // Codes beyond the last level route nowhere rather than wrap
            if (req[s] && mask[s] && (field[s] < `EVP_NUM_GP)) begin
                gp_req[field[s]] = 1'b1;
            end
        end
    end
endmodule : source_router
`default_nettype wire

// *** verilog/two_stage_event_prioritizer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "event_prio_params.svh"

module two_stage_event_prioritizer #(
    parameter int N_SRC = `EVP_NUM_SOURCES
) (
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic [N_SRC-1:0]         periph_req,
    input  wire logic [N_SRC-1:0]         sys_mask,
    input  wire logic [N_SRC-1:0]         source_wake_enable_bits,
    input  wire logic [6:0]               ded_req,
    input  wire logic [1:0]               sw_req,
    input  wire logic [15:0]              event_mask_bits,
    input  wire logic                     assign_wr,
    input  wire logic [2:0]               assign_idx,
    input  wire logic [31:0]              assign_data,
    input  wire logic                     ret_strobe,
    output logic      [15:0]              event_latch_bits,
    output logic      [15:0]              event_pending_bits,
    output logic                          svc_take,
    output logic      [3:0]               svc_idx,
    output logic      [N_SRC-1:0]         source_status_bits,
    output logic                          wake_req
);
    localparam int N_WORDS = N_SRC / `EVP_FIELDS_WORD;

    // Refuse widths that do not fill whole assignment words
    if ((N_SRC % `EVP_FIELDS_WORD) != 0 || N_SRC > 64 || N_SRC < 32) begin : g_bad_width
        $error("N_SRC must be a multiple of eight from 32 to 64");
    end

    // Whole state of the block
    typedef struct packed {
        logic                                      seen;    // Cleared only by reset
        logic [N_SRC-1:0][`EVP_FIELD_BITS-1:0]     field;   // Source assignment fields
        event_prio_pkg::event_vec_t                lvl;     // Sampled event levels
        event_prio_pkg::event_vec_t                prev;    // Levels one cycle older
        event_prio_pkg::event_vec_t                latch;   // Latched events
        event_prio_pkg::event_vec_t                pend;    // Active or nested events
        logic                                      take;    // Event accepted this cycle
        event_prio_pkg::event_idx_t                idx;     // Index of accepted event
        logic [N_SRC-1:0]                          status;  // Raw source status
        logic                                      wake;    // Wake request
    } state_t;

    state_t st;        // Current state
    state_t next_st;   // Next state

    logic [`EVP_NUM_GP-1:0]      gp_req;   // Routed level requests
    event_prio_pkg::event_vec_t  ev_in;    // All core-stage inputs
    event_prio_pkg::event_vec_t  rise;     // Detected rising edges
    event_prio_pkg::event_vec_t  cand;     // Latched and unmasked
    event_prio_pkg::event_vec_t  pend_lo;  // Pending after a return

    // Reset default of each source's level field
    function automatic event_prio_pkg::level_code_t dflt(input int id);
        if (id <= 10) begin
            return `EVP_CODE_LVL7;
        end else if (id == 12 || id == 13) begin
            return `EVP_CODE_LVL8;
        end else if (id >= 14 && id <= 19) begin
            return `EVP_CODE_LVL9;
        end else if (id >= 20 && id <= 25) begin
            return `EVP_CODE_LVL10;
        end else if (id >= 26 && id <= 30) begin
            return `EVP_CODE_LVL11;
        end else if (id >= 32 && id <= 41) begin
            return `EVP_CODE_LVL12;
        end else if (id >= 42 && id <= 46) begin
            return `EVP_CODE_LVL13;
        end else if (id == 48 || (id >= 51 && id <= 55)) begin
            return `EVP_CODE_LVL10;
        end else begin
            // Reserved and unlisted IDs sit at level 7; software masks them
            return `EVP_CODE_LVL7;
        end
    endfunction : dflt

    // Whole reset image of the assignment fields, fixed at elaboration
    function automatic logic [N_SRC-1:0][`EVP_FIELD_BITS-1:0] dflt_all();
        logic [N_SRC-1:0][`EVP_FIELD_BITS-1:0] img;
        img = '0;
        for (int s = 0; s < N_SRC; s++) begin
            img[s] = dflt(s);
        end
        return img;
    endfunction : dflt_all

    // Constant image keeps the asynchronous reset branch free of logic
    localparam logic [N_SRC-1:0][`EVP_FIELD_BITS-1:0] FIELD_RST = dflt_all();

    // System stage: mask and combine peripheral requests per level
    source_router #(
        .N_SRC (N_SRC)
    ) u_router (
        .req    (periph_req),
        .mask   (sys_mask),
        .field  (st.field),
        .gp_req (gp_req)
    );

    // Core stage input vector; position 4 is reserved and held low
    always_comb begin
        ev_in = '0;
        ev_in[`EVP_POS_EMU]   = ded_req[0];
        ev_in[`EVP_POS_RESET] = ded_req[1];
        ev_in[`EVP_POS_NMI]   = ded_req[2];
        ev_in[`EVP_POS_EXC]   = ded_req[3];
        ev_in[`EVP_POS_HWERR] = ded_req[5];
        ev_in[`EVP_POS_TIMER] = ded_req[6];
        ev_in[15:`EVP_POS_GP_BASE] = gp_req;
        // Software-raised events share the two lowest levels
        ev_in[15:`EVP_POS_SW_LO] = ev_in[15:`EVP_POS_SW_LO] | sw_req;
    end

    // Edge seen one cycle after sampling, so latch sets on the second edge
    assign rise = st.lvl & ~st.prev;
    assign cand = st.latch & (event_mask_bits | `EVP_UNMASKABLE);

    // A return retires the innermost, lowest numbered pending event
    assign pend_lo = ret_strobe ? (st.pend & (st.pend - 16'h0001)) : st.pend;

    // Next state of the whole block
    always_comb begin
        logic found;
        logic blocked;
        found   = 1'b0;
        blocked = 1'b0;
        next_st = st;
        next_st.seen   = 1'b1;
        next_st.lvl    = ev_in;
        next_st.prev   = st.lvl;
        next_st.take   = 1'b0;
        next_st.status = periph_req;
        next_st.wake   = |(periph_req & source_wake_enable_bits);
        next_st.pend   = pend_lo;
        // Pick the best candidate; only preempt when it beats all pending
        for (int k = 0; k < `EVP_NUM_EVENTS; k++) begin
            if (st.pend[k]) begin
                blocked = 1'b1;
            end
            if (!found && cand[k]) begin
                found = 1'b1;
                if (!blocked) begin
                    next_st.take     = 1'b1;
                    next_st.idx      = 4'(k);
                    next_st.pend[k]  = 1'b1;
                    next_st.latch[k] = 1'b0;
                end
            end
        end
        // A new edge wins over the clear so the next edge is queued
        next_st.latch = next_st.latch | rise;
        next_st.latch[`EVP_POS_RSVD] = 1'b0;
        // Software write of one word of eight fields
        if (assign_wr && (int'(assign_idx) < N_WORDS)) begin
            for (int f = 0; f < `EVP_FIELDS_WORD; f++) begin
                next_st.field[int'(assign_idx) * `EVP_FIELDS_WORD + f] =
                    assign_data[f*`EVP_FIELD_BITS +: `EVP_FIELD_BITS];
            end
        end
    end

    // State register; defaults restored on reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st       <= '0;
            st.field <= FIELD_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign event_latch_bits   = st.latch;
    assign event_pending_bits = st.pend;
    assign svc_take           = st.take;
    assign svc_idx            = st.idx;
    assign source_status_bits = st.status;
    assign wake_req           = st.wake;

    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_word_write;
        assign_wr && (int'(assign_idx) < N_WORDS);
    endsequence

    sequence s_accept;
        st.take;
    endsequence

    a_reset_defaults: assert property (!st.seen |->
        st.field[0] == `EVP_CODE_LVL7 && st.field[10] == `EVP_CODE_LVL7
        && st.field[12] == `EVP_CODE_LVL8 && st.field[19] == `EVP_CODE_LVL9
        && st.field[20] == `EVP_CODE_LVL10 && st.field[30] == `EVP_CODE_LVL11)
        else $error("assignment fields not at reset defaults");
    a_field_write: assert property (s_word_write |=>
        st.field[$past(assign_idx) * 8 + 7] == $past(assign_data[31:28])
        && st.field[$past(assign_idx) * 8] == $past(assign_data[3:0]))
        else $error("assignment word not stored in its eight fields");
    a_edge_latches: assert property (($past(rise) & ~st.latch) == 16'h0000)
        else $error("rising edge not latched");
    // Accepted event's latch is clear unless a fresh edge queued it again
    a_take_clears: assert property (s_accept |->
        (st.latch & ~$past(rise) & (16'h0001 << st.idx)) == 16'h0000)
        else $error("latch not cleared when pending set");
    a_min_latency: assert property ((st.pend & ~$past(st.pend) &
        ~($past(st.latch))) == 16'h0000)
        else $error("pending set without a prior latch");
    a_core_mask: assert property ((st.pend & ~$past(st.pend) &
        ~($past(event_mask_bits) | `EVP_UNMASKABLE)) == 16'h0000)
        else $error("masked event entered service");
    a_sys_mask: assert property (((periph_req & sys_mask) == '0)
        |-> gp_req == '0)
        else $error("masked peripheral reached the core stage");
    a_or_route: assert property ((periph_req[0] && sys_mask[0] &&
        st.field[0] < 9) |-> gp_req[st.field[0]])
        else $error("unmasked source missing from its level");
    a_best_first: assert property (st.take |->
        ($past(cand) & ((16'h0001 << st.idx) - 16'h0001)) == 16'h0000)
        else $error("a better event was passed over");
    a_rsvd_quiet: assert property ((st.pend[4] | st.latch[4]) == 1'b0)
        else $error("reserved event position became active");
endmodule : two_stage_event_prioritizer
`default_nettype wire
